// *** logic/fpc_pin_ctrl.v ***
// Floppy controller pin multiplexing with APB register access
// Behaviour
// - Master reset puts the controller idle and every disk output inactive.
// - Master reset restores digital output, data rate, config control, mode, configure, lock.
// - Master reset leaves the specify parameters as they are.
// - With function control bit 0 clear the media-sense pins are pulled-up inputs.
// - With function control bit 0 set the media-sense pins drive data rate, no pull-ups.
// - The two motor enables are active low and follow bits 4 and 5 of digital output.
// - Function enable bit 4 encodes the two motor enables to address four drives.
// - Function control bit 4 swaps the motor values, so the shared pin serves drive 0.
// - In shared port mode with floppy selected an extra active-low motor enable is driven.
// - The power-down pin shows power-down when power management bit 4 is set, else the inverse of rate bit 1.
// - Outside master reset, power-down out is high whenever any of the four power-down sources is active.
// - Function control bit 2 picks the shared pin as printer select or drive-two present.
// - The board holds the select high for a printer and low for a floppy drive.
// - In shared port mode with floppy selected read data is also taken from the shared pin.
// - The idle output is high whenever the controller is idle or powered down.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "fpc_defines.vh"
module fpc_pin_ctrl (
  input wire ref_clk_i,           // 25 MHz clock
  input wire rst_i,               // Async reset, active high
  input wire master_reset_input_i, // Master reset, active high
  input wire psel,                // APB select
  input wire penable,             // APB enable
  input wire pwrite,              // APB write
  input wire [11:0] paddr,        // APB byte address
  input wire [31:0] pwdata,       // APB write data
  output wire [31:0] prdata,      // APB read data
  output wire pready,             // APB ready
  output wire pslverr,            // APB error
  input wire read_strobe_n_i,     // Host read strobe, active low
  input wire ctrl_busy_i,         // Controller core busy
  input wire shared_sel_i,        // Shared printer/floppy select pin
  input wire rdata_n_i,           // Normal raw read data
  input wire shp_rdata_n_i,       // Shared-port raw read data
  output wire rdata_n_o,          // Merged raw read data
  input wire [1:0] media_sense_n_i, // Media sense pin inputs
  output reg [1:0] media_sense_o, // Media sense pin drive value
  output reg [1:0] media_sense_oe_n_o, // Media sense enable, low drives
  output reg [1:0] media_sense_pu_o, // Internal pull-up enable
  output reg motor_enable_0_n_o,  // Motor enable 0, active low
  output reg motor_enable_1_n_o,  // Motor enable 1, active low
  output reg shp_motor_n_o,       // Shared-port motor enable, active low
  output reg pwdn_pin_o,          // Power-down or rate-1 pin
  output reg power_down_out_o,    // Power-down state
  output reg idle_o,              // Idle indicator
  output reg printer_or_floppy_select_o, // Printer attached
  output reg second_drive_present_o, // Second drive present
  output reg shp_floppy_o         // Shared port carries floppy signals
);
  wire [7:0] dout_q;
  wire [7:0] dsr_q;
  wire [7:0] cfgc_q;
  wire [7:0] mode_q;
  wire [7:0] cfg_q;
  wire [7:0] lock_q;
  reg [7:0] fnc_q;
  reg [7:0] fen_q;
  reg [7:0] pwm_q;
  reg [7:0] paux_q;
  reg [7:0] spec_q;
  reg [1:0] ctrl_q;
  reg [31:0] rd_q;
  reg [7:0] rd_cnt_q;
  reg strobe_d1_q;
  reg m0;
  reg m1;
  wire wr_acc;
  wire rd_setup;
  wire mreset;
  wire shared_mode;
  wire shsel_mode;
  wire pwr_down;
  wire floppy_on_port;
  wire sm0;
  wire sm1;

  assign wr_acc = psel & penable & pwrite;
  // Read data is fetched in the setup cycle, so it already stands when the
  // zero-wait access phase completes
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mreset = master_reset_input_i;
  assign shared_mode = ctrl_q[`FPC_CTRL_SHARED];
  assign shsel_mode = fnc_q[`FPC_FNC_SHSEL];
  assign pwr_down = dsr_q[`FPC_DSR_PWRDN] | fen_q[`FPC_FEN_PWRDN] |
                    paux_q[`FPC_PAUX_PWRDN] | mode_q[`FPC_MODE_PWRDN];
  assign floppy_on_port = shared_mode & shsel_mode & ~shared_sel_i;

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `FPC_OFF_STAT);
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = rd_q;

  // Registers that master reset restores
  fpc_reg8 #(
    .RST_VAL(`FPC_DOUT_RST)
  ) u_dout (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(mreset),
    .we_i(wr_acc & hit(paddr, `FPC_OFF_DOUT)),
    .d_i(pwdata[7:0]),
    .q_o(dout_q)
  );

  fpc_reg8 #(
    .RST_VAL(`FPC_DSR_RST)
  ) u_dsr (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(mreset),
    .we_i(wr_acc & hit(paddr, `FPC_OFF_DSR)),
    .d_i(pwdata[7:0]),
    .q_o(dsr_q)
  );

  fpc_reg8 #(
    .RST_VAL(`FPC_CFGC_RST)
  ) u_cfgc (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(mreset),
    .we_i(wr_acc & hit(paddr, `FPC_OFF_CFGC)),
    .d_i(pwdata[7:0]),
    .q_o(cfgc_q)
  );

  fpc_reg8 #(
    .RST_VAL(`FPC_MODE_RST)
  ) u_mode (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(mreset),
    .we_i(wr_acc & hit(paddr, `FPC_OFF_MODE)),
    .d_i(pwdata[7:0]),
    .q_o(mode_q)
  );

  fpc_reg8 #(
    .RST_VAL(`FPC_CFG_RST)
  ) u_cfg (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(mreset),
    .we_i(wr_acc & hit(paddr, `FPC_OFF_CFG)),
    .d_i(pwdata[7:0]),
    .q_o(cfg_q)
  );

  fpc_reg8 #(
    .RST_VAL(`FPC_LOCK_RST)
  ) u_lock (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(mreset),
    .we_i(wr_acc & hit(paddr, `FPC_OFF_LOCK)),
    .d_i(pwdata[7:0]),
    .q_o(lock_q)
  );

  // Configuration registers outside the controller are untouched by master reset
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fnc_q <= `FPC_KEEP_RST;
      fen_q <= `FPC_KEEP_RST;
      pwm_q <= `FPC_KEEP_RST;
      paux_q <= `FPC_KEEP_RST;
      spec_q <= `FPC_KEEP_RST;
      ctrl_q <= 2'h0;
    end else if (wr_acc) begin
      if (hit(paddr, `FPC_OFF_FNC)) begin
        fnc_q <= pwdata[7:0];
      end
      if (hit(paddr, `FPC_OFF_FEN)) begin
        fen_q <= pwdata[7:0];
      end
      if (hit(paddr, `FPC_OFF_PWM)) begin
        pwm_q <= pwdata[7:0];
      end
      if (hit(paddr, `FPC_OFF_PAUX)) begin
        paux_q <= pwdata[7:0];
      end
      if (hit(paddr, `FPC_OFF_SPEC)) begin
        spec_q <= pwdata[7:0];
      end
      if (hit(paddr, `FPC_OFF_CTRL)) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

  // Host read strobes are counted so software can see activity
  // The delayed copy resets to the idle level, so no false edge follows reset
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_d1_q <= 1'b1;
      rd_cnt_q <= 8'h00;
    end else begin
      strobe_d1_q <= read_strobe_n_i;
      if (strobe_d1_q & ~read_strobe_n_i)
        rd_cnt_q <= rd_cnt_q + 8'h01;
    end
  end

  // Motor decode: two-drive direct or four-drive encoded
  always @* begin
    if (fen_q[`FPC_FEN_FOUR_DRV]) begin
      m0 = dout_q[`FPC_DOUT_MOTOR_ENABLE_0] | dout_q[`FPC_DOUT_MTR2];
      m1 = dout_q[`FPC_DOUT_MOTOR_ENABLE_1] | dout_q[`FPC_DOUT_MTR3];
    end else begin
      m0 = dout_q[`FPC_DOUT_MOTOR_ENABLE_0];
      m1 = dout_q[`FPC_DOUT_MOTOR_ENABLE_1];
    end
  end

  assign sm0 = fnc_q[`FPC_FNC_MTR_SWAP] ? m1 : m0;
  assign sm1 = fnc_q[`FPC_FNC_MTR_SWAP] ? m0 : m1;

  // Motor pins; master reset forces every one of them inactive
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      motor_enable_0_n_o <= 1'b1;
      motor_enable_1_n_o <= 1'b1;
      shp_motor_n_o <= 1'b1;
    end else if (mreset) begin
      motor_enable_0_n_o <= 1'b1;
      motor_enable_1_n_o <= 1'b1;
      shp_motor_n_o <= 1'b1;
    end else begin
      motor_enable_0_n_o <= ~sm0;
      motor_enable_1_n_o <= ~sm1;
      if (floppy_on_port) begin
        shp_motor_n_o <= ~sm1;
      end else begin
        shp_motor_n_o <= 1'b1;
      end
    end
  end

  // Media-sense pins: pulled-up inputs, or rate outputs with the pull-ups off
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      media_sense_o <= 2'h0;
      media_sense_oe_n_o <= 2'h3;
      media_sense_pu_o <= 2'h3;
    end else if (mreset) begin
      media_sense_o <= 2'h0;
      media_sense_oe_n_o <= 2'h3;
      media_sense_pu_o <= 2'h3;
    end else if (fnc_q[`FPC_FNC_SENSE_OUT]) begin
      media_sense_o <= dsr_q[1:0];
      media_sense_oe_n_o <= 2'h0;
      media_sense_pu_o <= 2'h0;
    end else begin
      media_sense_o <= 2'h0;
      media_sense_oe_n_o <= 2'h3;
      media_sense_pu_o <= 2'h3;
    end
  end

  // Power-down state, power-down pin and idle flag
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwdn_pin_o <= 1'b0;
      power_down_out_o <= 1'b0;
      idle_o <= 1'b1;
    end else if (mreset) begin
      pwdn_pin_o <= 1'b0;
      power_down_out_o <= 1'b0;
      idle_o <= 1'b1;
    end else begin
      power_down_out_o <= pwr_down;
      if (pwm_q[`FPC_PWM_PIN_SEL]) begin
        pwdn_pin_o <= pwr_down;
      end else begin
        pwdn_pin_o <= ~dsr_q[`FPC_DSR_RATE1];
      end
      idle_o <= ~ctrl_busy_i | pwr_down;
    end
  end

  // Meaning of the shared select pin and the shared-port floppy flag
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      printer_or_floppy_select_o <= 1'b0;
      second_drive_present_o <= 1'b0;
      shp_floppy_o <= 1'b0;
    end else if (mreset) begin
      printer_or_floppy_select_o <= 1'b0;
      second_drive_present_o <= 1'b0;
      shp_floppy_o <= 1'b0;
    end else begin
      printer_or_floppy_select_o <= shsel_mode & shared_sel_i;
      second_drive_present_o <= ~shsel_mode & shared_sel_i;
      shp_floppy_o <= floppy_on_port;
    end
  end

  // Shared-port read data only counts while the port carries a floppy drive
  assign rdata_n_o = rdata_n_i & (shp_floppy_o ? shp_rdata_n_i : 1'b1);

  // Read data registered in the setup cycle; a status read shows the state
  // of one cycle before the access completes
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        `FPC_OFF_DOUT: rd_q <= {24'h000000, dout_q};
        `FPC_OFF_DSR: rd_q <= {24'h000000, dsr_q};
        `FPC_OFF_CFGC: rd_q <= {24'h000000, cfgc_q};
        `FPC_OFF_FNC: rd_q <= {24'h000000, fnc_q};
        `FPC_OFF_FEN: rd_q <= {24'h000000, fen_q};
        `FPC_OFF_PWM: rd_q <= {24'h000000, pwm_q};
        `FPC_OFF_PAUX: rd_q <= {24'h000000, paux_q};
        `FPC_OFF_MODE: rd_q <= {24'h000000, mode_q};
        `FPC_OFF_CFG: rd_q <= {24'h000000, cfg_q};
        `FPC_OFF_LOCK: rd_q <= {24'h000000, lock_q};
        `FPC_OFF_SPEC: rd_q <= {24'h000000, spec_q};
        `FPC_OFF_CTRL: rd_q <= {30'h0, ctrl_q};
        `FPC_OFF_STAT: rd_q <= {16'h0000, rd_cnt_q, power_down_out_o, idle_o,
                                printer_or_floppy_select_o, second_drive_present_o,
                                shp_floppy_o, ~motor_enable_1_n_o, ~motor_enable_0_n_o,
                                pwdn_pin_o};
        default: rd_q <= 32'h00000000;
      endcase
    end
  end
endmodule

// *** logic/fpc_defines.vh ***
// Register offsets, field positions and reset values of the floppy pin control block
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
`define FPC_OFF_DOUT 12'h000
`define FPC_OFF_DSR 12'h004
`define FPC_OFF_CFGC 12'h008
`define FPC_OFF_FNC 12'h00c
`define FPC_OFF_FEN 12'h010
`define FPC_OFF_PWM 12'h014
`define FPC_OFF_PAUX 12'h018
`define FPC_OFF_MODE 12'h01c
`define FPC_OFF_CFG 12'h020
`define FPC_OFF_LOCK 12'h024
`define FPC_OFF_SPEC 12'h028
`define FPC_OFF_CTRL 12'h02c
`define FPC_OFF_STAT 12'h030
`define FPC_DOUT_RST 8'h00
`define FPC_DSR_RST 8'h02
`define FPC_CFGC_RST 8'h02
`define FPC_MODE_RST 8'h00
`define FPC_CFG_RST 8'h00
`define FPC_LOCK_RST 8'h00
`define FPC_KEEP_RST 8'h00
`define FPC_FNC_SENSE_OUT 0
`define FPC_FNC_SHSEL 2
`define FPC_FNC_MTR_SWAP 4
`define FPC_FEN_FOUR_DRV 4
`define FPC_FEN_PWRDN 3
`define FPC_PWM_PIN_SEL 4
`define FPC_DSR_PWRDN 6
`define FPC_DSR_RATE1 1
`define FPC_PAUX_PWRDN 0
`define FPC_MODE_PWRDN 0
`define FPC_DOUT_MOTOR_ENABLE_0 4
`define FPC_DOUT_MOTOR_ENABLE_1 5
`define FPC_DOUT_MTR2 6
`define FPC_DOUT_MTR3 7
`define FPC_CTRL_SHARED 0
`define FPC_CTRL_IDLE 1
`endif

// *** logic/fpc_reg8.v ***
// Byte-wide register with separate reset value and master-reset clear
`timescale 1ns/1ps
module fpc_reg8 #(
  parameter [7:0] RST_VAL = 8'h00
) (
  input wire ref_clk_i,   // Clock
  input wire rst_i,       // Async reset
  input wire clr_i,       // Synchronous restore to default
  input wire we_i,        // Write enable
  input wire [7:0] d_i,   // Write data
  output reg [7:0] q_o    // Stored value
);
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i)
      q_o <= RST_VAL;
    else if (clr_i)
      q_o <= RST_VAL;
    else if (we_i)
      q_o <= d_i;
  end
endmodule

// *** tb/fpc_pin_ctrl_properties.sv ***
// Concurrent checks on the floppy pin control ports
`timescale 1ns/1ps
module fpc_chk (
  input wire ref_clk_i, // Clock
  input wire rst_i, // Reset
  input wire master_reset_input_i, // Master reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire ctrl_busy_i, // Core busy
  input wire rdata_n_i, // Read data
  input wire shp_rdata_n_i, // Shared read data
  input wire rdata_n_o, // Merged read data
  input wire [1:0] media_sense_oe_n_o, // Sense enables
  input wire [1:0] media_sense_pu_o, // Pull-ups
  input wire motor_enable_0_n_o, // Motor 0
  input wire motor_enable_1_n_o, // Motor 1
  input wire shp_motor_n_o, // Shared motor
  input wire power_down_out_o, // Power-down
  input wire idle_o, // Idle
  input wire printer_or_floppy_select_o, // Printer
  input wire shp_floppy_o // Floppy on shared port
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire wr = psel && penable && pwrite;
  sequence s_mr_held;
    master_reset_input_i ##1 master_reset_input_i;
  endsequence
  property p_mr_out;
    master_reset_input_i |=> motor_enable_0_n_o && motor_enable_1_n_o && shp_motor_n_o;
  endproperty
  a_mr_out: assert property (p_mr_out) else $error("motor active after master reset");
  property p_mr_idle;
    s_mr_held |=> idle_o;
  endproperty
  a_mr_idle: assert property (p_mr_idle) else $error("not idle after master reset");
  property p_msen_in;
    media_sense_oe_n_o == 2'b11 |-> media_sense_pu_o == 2'b11;
  endproperty
  a_msen_in: assert property (p_msen_in) else $error("sense input without pull-up");
  property p_msen_out;
    media_sense_oe_n_o != 2'b11 |-> media_sense_oe_n_o == 2'b00 && media_sense_pu_o == 2'b00;
  endproperty
  a_msen_out: assert property (p_msen_out) else $error("sense output with pull-up");
  property p_rdata;
    rdata_n_o == (rdata_n_i & (shp_rdata_n_i | !shp_floppy_o));
  endproperty
  a_rdata: assert property (p_rdata) else $error("merged read data wrong");
  property p_pd_idle;
    power_down_out_o |-> idle_o;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("powered down but not idle");
  property p_busy_idle;
    !ctrl_busy_i |=> idle_o;
  endproperty
  a_busy_idle: assert property (p_busy_idle) else $error("idle core not flagged");
  property p_printer;
    printer_or_floppy_select_o |-> !shp_floppy_o;
  endproperty
  a_printer: assert property (p_printer) else $error("printer and floppy on shared port");
  property p_shp_motor;
    !shp_floppy_o |-> shp_motor_n_o;
  endproperty
  a_shp_motor: assert property (p_shp_motor) else $error("shared motor without floppy");
  property p_motor_hold;
    !$past(wr) && !$past(wr, 2) && !$past(master_reset_input_i) && !$past(master_reset_input_i, 2)
      |-> $stable(motor_enable_0_n_o) && $stable(motor_enable_1_n_o);
  endproperty
  a_motor_hold: assert property (p_motor_hold) else $error("motor moved without a write");
endmodule
bind fpc_pin_ctrl fpc_chk u_chk (.ref_clk_i, .rst_i, .master_reset_input_i, .psel, .penable,
  .pwrite, .ctrl_busy_i, .rdata_n_i, .shp_rdata_n_i, .rdata_n_o, .media_sense_oe_n_o,
  .media_sense_pu_o, .motor_enable_0_n_o, .motor_enable_1_n_o, .shp_motor_n_o,
  .power_down_out_o, .idle_o, .printer_or_floppy_select_o, .shp_floppy_o);

// *** tb/fpc_drive_model.sv ***
// Drive or printer standing on the shared and normal floppy pins
`timescale 1ns/1ps
module fpc_drive_model (
  input wire printer_i, // Printer attached instead of a drive
  input wire [1:0] pulse_i, // Read pulse on normal [0] or shared [1] pin
  input wire [1:0] ms_drv_i, // Media sense drive value
  input wire [1:0] ms_oe_n_i, // Media sense enable, low drives
  input wire [1:0] ms_pu_i, // Internal pull-ups
  output wire shared_sel_o, // Shared select pin
  output wire rdata_n_o, // Normal read data
  output wire shp_rdata_n_o, // Shared read data
  output wire [1:0] media_sense_n_o // Media sense wire level
);
  assign shared_sel_o = printer_i;
  assign rdata_n_o = !pulse_i[0];
  // A printer never answers on the read data line
  assign shp_rdata_n_o = !(pulse_i[1] && !printer_i);
  // Undriven, unpulled lines show the inverse so a floating pin cannot pass
  assign media_sense_n_o = (~ms_oe_n_i & ms_drv_i) | (ms_oe_n_i & (ms_pu_i | ~ms_drv_i));
endmodule

// *** tb/fpc_pin_ctrl_tb.sv ***
// Self-checking bench of the floppy pin control block
`timescale 1ns/1ps
`include "fpc_defines.vh"
module fpc_pin_ctrl_tb;
  logic ref_clk_i = 0, rst_i = 1, master_reset_input_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic ctrl_busy_i = 0, prn = 0, read_strobe_n_i = 1;
  logic [1:0] pulse = 2'b00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, err, rdat;
  wire [31:0] prdata;
  wire pready, pslverr, shared_sel_i, rdata_n_i, shp_rdata_n_i, rdata_n_o, m0, m1, pm, pdp, pdo;
  wire idle_o, pof, drv_two, shf;
  wire [1:0] media_sense_n_i, media_sense_o, media_sense_oe_n_o, media_sense_pu_o;
  int fails = 0, checks = 0;
  fpc_pin_ctrl u_dut (.ref_clk_i, .rst_i, .master_reset_input_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .read_strobe_n_i, .ctrl_busy_i,
    .shared_sel_i, .rdata_n_i, .shp_rdata_n_i, .rdata_n_o, .media_sense_n_i, .media_sense_o,
    .media_sense_oe_n_o, .media_sense_pu_o, .motor_enable_0_n_o(m0), .motor_enable_1_n_o(m1),
    .shp_motor_n_o(pm), .pwdn_pin_o(pdp), .power_down_out_o(pdo), .idle_o,
    .printer_or_floppy_select_o(pof), .second_drive_present_o(drv_two), .shp_floppy_o(shf));
  fpc_drive_model u_drv (.printer_i(prn), .pulse_i(pulse), .ms_drv_i(media_sense_o),
    .ms_oe_n_i(media_sense_oe_n_o), .ms_pu_i(media_sense_pu_o), .shared_sel_o(shared_sel_i),
    .rdata_n_o(rdata_n_i), .shp_rdata_n_o(shp_rdata_n_i), .media_sense_n_o(media_sense_n_i));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  task chk(input [31:0] g, input [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input [11:0] a, input [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    err = {31'h0, pslverr};
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Outputs follow a write one edge after it lands
  task wt;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task w(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
    wt;
  endtask
  // Read data is taken at the edge that completes the access
  task rd(input [11:0] a, input [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, m);
  endtask
  task t_regs;
    rd(`FPC_OFF_DSR, 32'h02, "rate reset");
    rd(`FPC_OFF_CFGC, 32'h02, "config reset");
    rd(12'h0fc, 32'h0, "unmapped read");
    chk(err, 32'h1, "unmapped error");
    repeat (3) begin
      @(posedge ref_clk_i) read_strobe_n_i <= 1'b0;
      @(posedge ref_clk_i) read_strobe_n_i <= 1'b1;
    end
    apb(1'b0, `FPC_OFF_STAT, 32'h0);
    chk({24'h0, rdat[15:8]}, 32'h3, "strobe count");
    $display("test regs done");
  endtask
  task mot(input [7:0] function_control_reg, input [7:0] function_enable_reg, input [7:0] digital_output_reg, input [1:0] e);
    w(`FPC_OFF_FNC, function_control_reg);
    w(`FPC_OFF_FEN, function_enable_reg);
    w(`FPC_OFF_DOUT, digital_output_reg);
    chk({m1, m0}, e, "motor pins");
  endtask
  task t_motor;
    mot(8'h00, 8'h00, 8'h10, 2'b10);
    mot(8'h00, 8'h00, 8'h20, 2'b01);
    mot(8'h10, 8'h00, 8'h10, 2'b01);
    mot(8'h00, 8'h10, 8'h40, 2'b10);
    mot(8'h00, 8'h10, 8'h80, 2'b01);
    w(`FPC_OFF_FNC, 8'h01);
    chk({media_sense_oe_n_o, media_sense_pu_o, media_sense_o}, 6'h02, "sense out");
    w(`FPC_OFF_FNC, 8'h00);
    chk({media_sense_oe_n_o, media_sense_pu_o}, 4'hf, "sense in");
    $display("test motor done");
  endtask
  task pds(input [11:0] a, input [7:0] v, input [7:0] r);
    w(a, v);
    chk({pdp, pdo, idle_o}, 3'b111, "powered down");
    w(a, r);
    chk({pdp, pdo, idle_o}, 3'b000, "powered up");
  endtask
  task t_pd;
    @(posedge ref_clk_i) ctrl_busy_i <= 1'b1;
    w(`FPC_OFF_DSR, 8'h00);
    chk({pdp, pdo, idle_o}, 3'b100, "rate pin");
    w(`FPC_OFF_PWM, 8'h10);
    pds(`FPC_OFF_DSR, 8'h42, 8'h02);
    pds(`FPC_OFF_FEN, 8'h08, 8'h00);
    pds(`FPC_OFF_PAUX, 8'h01, 8'h00);
    pds(`FPC_OFF_MODE, 8'h01, 8'h00);
    @(posedge ref_clk_i) ctrl_busy_i <= 1'b0;
    wt;
    chk(idle_o, 1'b1, "idle");
    $display("test power done");
  endtask
  task t_share;
    w(`FPC_OFF_CTRL, 8'h01);
    w(`FPC_OFF_FNC, 8'h04);
    w(`FPC_OFF_DOUT, 8'h20);
    chk({shf, pof, pm}, 3'b100, "floppy on shared port");
    @(posedge ref_clk_i) pulse <= 2'b10;
    #1;
    chk(rdata_n_o, 1'b0, "shared read data");
    @(posedge ref_clk_i) pulse <= 2'b01;
    #1;
    chk(rdata_n_o, 1'b0, "normal read data");
    @(posedge ref_clk_i) pulse <= 2'b00;
    prn <= 1'b1;
    wt;
    chk({shf, pof, pm}, 3'b011, "printer on shared port");
    w(`FPC_OFF_FNC, 8'h00);
    chk({pof, drv_two}, 2'b01, "drive present mode");
    w(`FPC_OFF_CTRL, 8'h00);
    $display("test shared done");
  endtask
  task t_mr;
    w(`FPC_OFF_SPEC, 8'h5a);
    w(`FPC_OFF_DOUT, 8'h30);
    @(posedge ref_clk_i) master_reset_input_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    master_reset_input_i <= 1'b0;
    wt;
    chk({m0, m1}, 2'b11, "motors inactive");
    rd(`FPC_OFF_DOUT, 32'h0, "output reg restored");
    rd(`FPC_OFF_SPEC, 32'h5a, "specify kept");
    $display("test master reset done");
  endtask
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_motor;
    t_pd;
    t_share;
    t_mr;
    end_sim;
  end
endmodule
